// ### include/rpcap_pkg.sv
// Package for the root port capability and control register bank.
// Holds the register offsets, field positions, reset values and fixed decodes.
// Assumes byte offsets in configuration space with dword-aligned accesses.
package rpcap_pkg;
    // Byte offsets of the registers in configuration space
    localparam logic [7:0] RPCAP_ROOT_CAP_OFS = 8'hae;
    localparam logic [7:0] RPCAP_ROOT_STS_OFS = 8'hb0;
    localparam logic [7:0] RPCAP_DEVICE_CAPABILITIES_TWO_OFS = 8'hb4;
    localparam logic [7:0] RPCAP_DEVCTL2_OFS = 8'hb8;
    localparam logic [7:0] RPCAP_LNKCTL2_OFS = 8'hc0;
    localparam logic [7:0] RPCAP_LINK_STATUS_TWO_OFS = 8'hc2;
    localparam logic [7:0] RPCAP_POWER_MGMT_CAPABILITY_OFS = 8'he0;
    localparam logic [7:0] RPCAP_DMI_POWER_MGMT_CTRL_STATUS_OFS = 8'he4;
    localparam logic [7:0] RPCAP_FINE_OFS = 8'he8;

    // Root status fields
    localparam int RPCAP_PME_STS_BIT = 16;
    localparam int RPCAP_PME_PEND_BIT = 17;

    // Fixed read-only values
    localparam logic [15:0] RPCAP_ROOT_CAP_VAL = 16'h0001;
    localparam logic [31:0] RPCAP_DEVICE_CAPABILITIES_TWO_VAL = 32'h0000_003e;
    localparam logic [31:0] RPCAP_POWER_MGMT_CAPABILITY_VAL = 32'hc803_0001;

    // Device control 2 fields
    localparam int RPCAP_CTO_DIS_BIT = 4;
    localparam int RPCAP_ARI_EN_BIT = 5;

    // Link control 2 fields
    localparam int RPCAP_SEL_DEEMPH_BIT = 6;
    localparam int RPCAP_AUTO_DIS_BIT = 5;
    localparam int RPCAP_ENTER_COMP_BIT = 4;
    localparam int RPCAP_MARGIN_LSB = 7;
    localparam int RPCAP_MOD_COMP_BIT = 10;
    localparam int RPCAP_COMP_SOS_BIT = 11;
    localparam int RPCAP_COMP_DEEMPH_BIT = 12;

    // Link speed encodings
    localparam logic [3:0] RPCAP_SPEED_GEN1 = 4'h1;
    localparam logic [3:0] RPCAP_SPEED_GEN2 = 4'h2;
    localparam logic [3:0] RPCAP_TSPEED_RST = 4'h2;

    // Power states
    localparam logic [1:0] RPCAP_PSTATE_D0 = 2'h0;
    localparam logic [1:0] RPCAP_PSTATE_D3 = 2'h3;

    // Completion time-out encodings
    localparam logic [3:0] RPCAP_CTO_10_50MS = 4'h0;
    localparam logic [3:0] RPCAP_CTO_RSV1 = 4'h1;
    localparam logic [3:0] RPCAP_CTO_RSV2 = 4'h2;
    localparam logic [3:0] RPCAP_CTO_16_55MS = 4'h5;
    localparam logic [3:0] RPCAP_CTO_65_210MS = 4'h6;
    localparam logic [3:0] RPCAP_CTO_260_900MS = 4'h9;
    localparam logic [3:0] RPCAP_CTO_1_3S = 4'ha;
    localparam logic [3:0] RPCAP_CTO_4_13S = 4'hd;
    localparam logic [3:0] RPCAP_CTO_17_64S = 4'he;

    // Time-out values in ms chosen inside each range; fixed except 17-64 s, which is a base plus fine steps
    localparam logic [15:0] RPCAP_CTO_A_MS = 16'd30;
    localparam logic [15:0] RPCAP_CTO_B_MS = 16'd40;
    localparam logic [15:0] RPCAP_CTO_C_MS = 16'd130;
    localparam logic [15:0] RPCAP_CTO_D_MS = 16'd500;
    localparam logic [15:0] RPCAP_CTO_E_MS = 16'd2000;
    localparam logic [15:0] RPCAP_CTO_F_MS = 16'd8000;
    localparam logic [15:0] RPCAP_CTO_G_BASE_MS = 16'd17000;
    localparam logic [15:0] RPCAP_CTO_G_STEP_MS = 16'd184;
endpackage

// ### rtl/rpcap_regs.sv
// Root port capability, root status, control 2 and power-management registers.
// Assumes a single-cycle configuration access port on the core clock, a hard
// reset and a separate power-good reset that alone re-initialises sticky bits.
`timescale 1ns/1ns
`default_nettype none

module rpcap_regs
    import rpcap_pkg::*;
#(
    parameter bit IS_DMI = 1'b0,
    parameter logic [3:0] MAX_SPEED = RPCAP_SPEED_GEN2,
    parameter logic [3:0] TSPEED_RESET = RPCAP_TSPEED_RST
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic pwrgood_reset_i,
    input wire logic clk_en_i,
    input wire logic cfg_wr_i,
    input wire logic cfg_rd_i,
    input wire logic [7:0] cfg_addr_i,
    input wire logic [3:0] cfg_be_i,
    input wire logic [31:0] cfg_wdata_i,
    output logic [31:0] cfg_rdata_o,
    output logic cfg_rvalid_o,
    input wire logic pme_link_i,
    input wire logic [15:0] pme_link_reqid_i,
    input wire logic pme_internal_i,
    input wire logic [7:0] port_bus_number_i,
    input wire logic [4:0] port_device_number_i,
    input wire logic link_gen2_i,
    input wire logic link_deemph_3p5_i,
    output logic ari_enable_o,
    output logic cto_disable_o,
    output logic [3:0] cto_range_o,
    output logic [15:0] cto_timeout_ms_o,
    output logic compliance_deemph_3p5_o,
    output logic compliance_sos_o,
    output logic enter_mod_compliance_o,
    output logic [2:0] transmit_margin_o,
    output logic upstream_deemph_3p5_o,
    output logic autonomous_speed_disable_o,
    output logic enter_compliance_o,
    output logic [3:0] target_speed_o,
    output logic [1:0] power_state_o
);

    if (MAX_SPEED != RPCAP_SPEED_GEN1 && MAX_SPEED != RPCAP_SPEED_GEN2) begin : g_bad_speed
        $error("MAX_SPEED must be Gen1 or Gen2");
    end
    if (TSPEED_RESET > MAX_SPEED || TSPEED_RESET == 4'h0) begin : g_bad_tspeed
        $error("TSPEED_RESET must be a supported speed");
    end

    function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic dword_hit(input logic [7:0] addr, input logic [7:0] ofs);
        return addr[7:2] == ofs[7:2];
    endfunction

    // Hard-reset state
    logic pme_sts_q, pme_sts_d;
    logic pme_pend_q, pme_pend_d;
    logic [15:0] pme_reqid_q, pme_reqid_d;
    logic [15:0] pend_id_q, pend_id_d;
    logic ari_q, cto_dis_q, auto_dis_q, sel_deemph_q, sel_locked_q;
    logic [3:0] cto_val_q;
    logic [7:0] fine_q;
    logic [1:0] pstate_q;
    logic [31:0] rdata_q;
    logic rvalid_q;
    // Sticky state, kept across hard reset
    logic comp_deemph_q, comp_sos_q, mod_comp_q, enter_comp_q;
    logic [2:0] margin_q;
    logic [3:0] tspeed_q;

    // Access decode
    wire wr_en = cfg_wr_i && clk_en_i;
    wire wr_rsts = wr_en && dword_hit(cfg_addr_i, RPCAP_ROOT_STS_OFS);
    wire wr_dctl = wr_en && dword_hit(cfg_addr_i, RPCAP_DEVCTL2_OFS);
    wire wr_lctl = wr_en && dword_hit(cfg_addr_i, RPCAP_LNKCTL2_OFS);
    wire wr_dmi_power_mgmt_ctrl_status = wr_en && dword_hit(cfg_addr_i, RPCAP_DMI_POWER_MGMT_CTRL_STATUS_OFS);
    wire wr_fine = wr_en && dword_hit(cfg_addr_i, RPCAP_FINE_OFS);

    // PME event capture
    wire pme_evt = pme_link_i || pme_internal_i;
    wire [15:0] own_id = {port_bus_number_i, port_device_number_i, 3'h0};
    wire [15:0] evt_id = pme_link_i ? pme_link_reqid_i : own_id;
    wire pme_clear = wr_rsts && cfg_be_i[2] && cfg_wdata_i[RPCAP_PME_STS_BIT];

    always_comb begin
        pme_sts_d = pme_sts_q;
        pme_pend_d = pme_pend_q;
        pme_reqid_d = pme_reqid_q;
        pend_id_d = pend_id_q;
        if (pme_clear && pme_pend_q) begin
            // Queued PME is delivered in the clearing cycle itself
            pme_sts_d = 1'b1;
            pme_reqid_d = pend_id_q;
            pme_pend_d = 1'b0;
        end else if (pme_clear) begin
            pme_sts_d = 1'b0;
        end
        if (pme_evt) begin
            if (!pme_sts_d) begin
                pme_sts_d = 1'b1;
                pme_reqid_d = evt_id;
            end else begin
                // One-deep queue: a later PME replaces the queued one
                pme_pend_d = 1'b1;
                pend_id_d = evt_id;
            end
        end
    end

    // Write data per register
    wire [31:0] dctl_w = merge_be({16'h0, 10'h0, ari_q, cto_dis_q, cto_val_q},
                                  cfg_wdata_i, cfg_be_i);
    wire [31:0] lctl_old = {16'h0, 3'h0, comp_deemph_q, comp_sos_q, mod_comp_q, margin_q,
                            sel_deemph_q, auto_dis_q, enter_comp_q, tspeed_q};
    wire [31:0] lctl_w = merge_be(lctl_old, cfg_wdata_i, cfg_be_i);
    wire [1:0] pstate_w = cfg_wdata_i[1:0];
    wire pstate_ok = cfg_be_i[0] && (pstate_w == RPCAP_PSTATE_D0 || pstate_w == RPCAP_PSTATE_D3);

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pme_sts_q <= 1'b0;
            pme_pend_q <= 1'b0;
            pme_reqid_q <= 16'h0000;
            pend_id_q <= 16'h0000;
        end else if (clk_en_i) begin
            pme_sts_q <= pme_sts_d;
            pme_pend_q <= pme_pend_d;
            pme_reqid_q <= pme_reqid_d;
            pend_id_q <= pend_id_d;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ari_q <= 1'b0;
            cto_dis_q <= 1'b0;
            cto_val_q <= RPCAP_CTO_10_50MS;
        end else if (wr_dctl) begin
            ari_q <= dctl_w[RPCAP_ARI_EN_BIT];
            cto_dis_q <= dctl_w[RPCAP_CTO_DIS_BIT];
            cto_val_q <= dctl_w[3:0];
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            auto_dis_q <= 1'b0;
            sel_deemph_q <= 1'b0;
            sel_locked_q <= 1'b0;
        end else if (wr_lctl) begin
            auto_dis_q <= lctl_w[RPCAP_AUTO_DIS_BIT];
            if (!sel_locked_q && cfg_be_i[0]) begin
                sel_deemph_q <= lctl_w[RPCAP_SEL_DEEMPH_BIT];
                sel_locked_q <= 1'b1;
            end
        end
    end

    // Sticky bits survive hard reset; only power-good re-initialises them
    always_ff @(posedge clk_i or posedge pwrgood_reset_i) begin
        if (pwrgood_reset_i) begin
            comp_deemph_q <= 1'b0;
            comp_sos_q <= 1'b0;
            mod_comp_q <= 1'b0;
            margin_q <= 3'h0;
            enter_comp_q <= 1'b0;
            tspeed_q <= TSPEED_RESET;
        end else if (wr_lctl) begin
            comp_deemph_q <= lctl_w[RPCAP_COMP_DEEMPH_BIT];
            comp_sos_q <= lctl_w[RPCAP_COMP_SOS_BIT];
            mod_comp_q <= lctl_w[RPCAP_MOD_COMP_BIT];
            margin_q <= lctl_w[RPCAP_MARGIN_LSB +: 3];
            enter_comp_q <= lctl_w[RPCAP_ENTER_COMP_BIT];
            tspeed_q <= lctl_w[3:0];
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            fine_q <= 8'h00;
            pstate_q <= RPCAP_PSTATE_D0;
        end else begin
            if (wr_fine && cfg_be_i[0]) begin
                fine_q <= cfg_wdata_i[7:0];
            end
            if (wr_dmi_power_mgmt_ctrl_status && pstate_ok) begin
                pstate_q <= pstate_w;
            end
        end
    end

    // Completion time-out decode
    function automatic logic [3:0] cto_alias(input logic [3:0] v);
        logic [3:0] r;
        r = v;
        if (v == RPCAP_CTO_RSV1 || v == RPCAP_CTO_RSV2) begin
            r = RPCAP_CTO_10_50MS;
        end
        return r;
    endfunction

    function automatic logic [15:0] cto_ms(input logic [3:0] v, input logic [7:0] fine);
        logic [15:0] r;
        unique case (v)
            RPCAP_CTO_16_55MS: r = RPCAP_CTO_B_MS;
            RPCAP_CTO_65_210MS: r = RPCAP_CTO_C_MS;
            RPCAP_CTO_260_900MS: r = RPCAP_CTO_D_MS;
            RPCAP_CTO_1_3S: r = RPCAP_CTO_E_MS;
            RPCAP_CTO_4_13S: r = RPCAP_CTO_F_MS;
            RPCAP_CTO_17_64S: r = 16'(RPCAP_CTO_G_BASE_MS + 16'(fine) * RPCAP_CTO_G_STEP_MS);
            default: r = RPCAP_CTO_A_MS;
        endcase
        return r;
    endfunction

    wire [3:0] cto_eff = cto_alias(cto_val_q);
    wire [3:0] tspeed_eff = (tspeed_q == RPCAP_SPEED_GEN1 || tspeed_q == MAX_SPEED)
                            ? tspeed_q : RPCAP_SPEED_GEN1;
    wire lnksts_bit0 = link_gen2_i && link_deemph_3p5_i;

    // Read data assembly
    wire [31:0] rsts_word = {14'h0, pme_pend_q, pme_sts_q, pme_reqid_q};
    wire [31:0] rcap_word = {RPCAP_ROOT_CAP_VAL, 16'h0000};
    wire [31:0] dctl_word = {16'h0, 10'h0, ari_q, cto_dis_q, cto_val_q};
    wire [31:0] lnk_word = {15'h0, lnksts_bit0, lctl_old[15:0]};
    wire [31:0] power_mgmt_capability_word = IS_DMI ? 32'h0 : RPCAP_POWER_MGMT_CAPABILITY_VAL;
    wire [31:0] dmi_power_mgmt_ctrl_status_word = {30'h0, pstate_q};
    wire [31:0] fine_word = {24'h0, fine_q};
    wire [31:0] rd_word =
        dword_hit(cfg_addr_i, RPCAP_ROOT_CAP_OFS) ? rcap_word :
        dword_hit(cfg_addr_i, RPCAP_ROOT_STS_OFS) ? rsts_word :
        dword_hit(cfg_addr_i, RPCAP_DEVICE_CAPABILITIES_TWO_OFS) ? RPCAP_DEVICE_CAPABILITIES_TWO_VAL :
        dword_hit(cfg_addr_i, RPCAP_DEVCTL2_OFS) ? dctl_word :
        dword_hit(cfg_addr_i, RPCAP_LNKCTL2_OFS) ? lnk_word :
        dword_hit(cfg_addr_i, RPCAP_POWER_MGMT_CAPABILITY_OFS) ? power_mgmt_capability_word :
        dword_hit(cfg_addr_i, RPCAP_DMI_POWER_MGMT_CTRL_STATUS_OFS) ? dmi_power_mgmt_ctrl_status_word :
        dword_hit(cfg_addr_i, RPCAP_FINE_OFS) ? fine_word : 32'h0;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_q <= 32'h0;
            rvalid_q <= 1'b0;
        end else if (clk_en_i) begin
            rvalid_q <= cfg_rd_i;
            if (cfg_rd_i) begin
                rdata_q <= rd_word;
            end
        end
    end

    assign cfg_rdata_o = rdata_q;
    assign cfg_rvalid_o = rvalid_q;
    assign ari_enable_o = ari_q;
    assign cto_disable_o = cto_dis_q;
    assign cto_range_o = cto_eff;
    assign cto_timeout_ms_o = cto_ms(cto_eff, fine_q);
    assign compliance_deemph_3p5_o = comp_deemph_q;
    assign compliance_sos_o = comp_sos_q;
    assign enter_mod_compliance_o = mod_comp_q;
    assign transmit_margin_o = margin_q;
    assign upstream_deemph_3p5_o = link_gen2_i && sel_deemph_q;
    assign autonomous_speed_disable_o = auto_dis_q;
    assign enter_compliance_o = enter_comp_q;
    assign target_speed_o = tspeed_eff;
    assign power_state_o = pstate_q;

    // Checks
    sequence s_clear_with_pending;
        clk_en_i && pme_clear && pme_pend_q && !pme_evt;
    endsequence

    sequence s_delivered(logic [15:0] id);
        pme_sts_q && !pme_pend_q && pme_reqid_q == id;
    endsequence

    pme_set_a: assert property (@(posedge clk_i) disable iff (reset_i)
        clk_en_i && pme_evt && !pme_sts_q |=> pme_sts_q && pme_reqid_q == $past(evt_id))
        else $error("PME did not set status");
    pme_pend_a: assert property (@(posedge clk_i) disable iff (reset_i)
        clk_en_i && pme_evt && pme_sts_q && !pme_clear |=> pme_pend_q && pme_sts_q)
        else $error("Second PME not marked pending");
    pme_deliver_a: assert property (@(posedge clk_i) disable iff (reset_i)
        s_clear_with_pending |=> s_delivered($past(pend_id_q)))
        else $error("Pending PME not delivered on clear");
    pme_w1c_a: assert property (@(posedge clk_i) disable iff (reset_i)
        clk_en_i && pme_clear && !pme_pend_q && !pme_evt |=> !pme_sts_q)
        else $error("Write one did not clear PME status");
    cto_alias_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (cto_val_q == RPCAP_CTO_RSV1 || cto_val_q == RPCAP_CTO_RSV2)
        |-> cto_range_o == RPCAP_CTO_10_50MS && cto_timeout_ms_o == RPCAP_CTO_A_MS)
        else $error("Reserved time-out code not aliased");
    speed_fallback_a: assert property (@(posedge clk_i) disable iff (pwrgood_reset_i)
        tspeed_q != RPCAP_SPEED_GEN1 && tspeed_q != MAX_SPEED
        |-> target_speed_o == RPCAP_SPEED_GEN1)
        else $error("Unsupported target speed not reduced to Gen1");
    deemph_gen1_a: assert property (@(posedge clk_i) disable iff (reset_i)
        !link_gen2_i |-> !upstream_deemph_3p5_o && !lnk_word[16])
        else $error("De-emphasis active at Gen1");
    write_once_a: assert property (@(posedge clk_i) disable iff (reset_i)
        sel_locked_q && wr_lctl |=> $stable(sel_deemph_q))
        else $error("Write-once bit changed twice");
    pstate_keep_a: assert property (@(posedge clk_i) disable iff (reset_i)
        wr_dmi_power_mgmt_ctrl_status && cfg_be_i[0] && (pstate_w == 2'h1 || pstate_w == 2'h2)
        |=> power_state_o == $past(power_state_o))
        else $error("Unsupported power state accepted");
    ro_read_a: assert property (@(posedge clk_i) disable iff (reset_i)
        clk_en_i && cfg_rd_i && dword_hit(cfg_addr_i, RPCAP_DEVICE_CAPABILITIES_TWO_OFS)
        |=> cfg_rvalid_o && cfg_rdata_o == RPCAP_DEVICE_CAPABILITIES_TWO_VAL)
        else $error("Device capability 2 read wrong");
    rcap_read_a: assert property (@(posedge clk_i) disable iff (reset_i)
        clk_en_i && cfg_rd_i && dword_hit(cfg_addr_i, RPCAP_ROOT_CAP_OFS)
        |=> cfg_rdata_o[31:16] == RPCAP_ROOT_CAP_VAL && cfg_rdata_o[15:0] == 16'h0000)
        else $error("Root capability read wrong");
    rsts_rsvd_a: assert property (@(posedge clk_i) disable iff (reset_i)
        clk_en_i && cfg_rd_i && dword_hit(cfg_addr_i, RPCAP_ROOT_STS_OFS)
        |=> cfg_rdata_o[31:18] == 14'h0000)
        else $error("Root status reserved bits not zero");
    dmi_power_mgmt_ctrl_status_zero_a: assert property (@(posedge clk_i) disable iff (reset_i)
        clk_en_i && cfg_rd_i && dword_hit(cfg_addr_i, RPCAP_DMI_POWER_MGMT_CTRL_STATUS_OFS)
        |=> cfg_rdata_o[31:2] == 30'h0000_0000)
        else $error("Power control upper bits not zero");
    power_mgmt_capability_dmi_a: assert property (@(posedge clk_i) disable iff (reset_i)
        IS_DMI && clk_en_i && cfg_rd_i && dword_hit(cfg_addr_i, RPCAP_POWER_MGMT_CAPABILITY_OFS)
        |=> cfg_rdata_o == 32'h0000_0000)
        else $error("DMI power capability not zero");
    rvalid_pulse_a: assert property (@(posedge clk_i) disable iff (reset_i)
        clk_en_i && !cfg_rd_i |=> !cfg_rvalid_o)
        else $error("Read valid without a read");
    // A stalled core clock must leave PME status and pending, power state and read valid unchanged
    freeze_a: assert property (@(posedge clk_i) disable iff (reset_i)
        !clk_en_i |=> $stable(pme_sts_q) && $stable(pme_pend_q)
        && $stable(power_state_o) && $stable(cfg_rvalid_o))
        else $error("State changed while clock enable low");

endmodule // rpcap_regs

`default_nettype wire

// ### bench/rpcap_link_model.sv
// Downstream link partner: sends PME messages and reports link speed and de-emphasis.
// Assumes the core clock of the register bank; drives on the falling edge.
`timescale 1ns/1ns
`default_nettype none

module rpcap_link_model (
    input wire logic clk_i,
    output logic pme_o,
    output logic [15:0] reqid_o,
    output logic gen2_o,
    output logic deemph_3p5_o
);
    initial begin
        pme_o = 1'b0;
        reqid_o = 16'h0000;
        gen2_o = 1'b0;
        deemph_3p5_o = 1'b0;
    end

    task automatic send_pme(input logic [15:0] id);
        @(negedge clk_i);
        pme_o = 1'b1;
        reqid_o = id;
        @(negedge clk_i);
        pme_o = 1'b0;
        // The ID is only meaningful with the strobe, so stale lines are scrambled
        reqid_o = ~id;
    endtask

    task automatic set_link(input logic g2, input logic d35);
        @(negedge clk_i);
        gen2_o = g2;
        deemph_3p5_o = d35;
    endtask
endmodule // rpcap_link_model

`default_nettype wire

// ### bench/tb_pcie_root_port_cap_ctrl_regs.sv
// Self-checking bench for the root port register bank.
// Assumes the package and the link model are compiled first.
`timescale 1ns/1ns
`default_nettype none

module tb_pcie_root_port_cap_ctrl_regs;
    import rpcap_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic pg_rst = 1'b1;
    logic en = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [3:0] be = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic pme_int = 1'b0;
    logic [7:0] bus_no = 8'h5a;
    logic [4:0] dev_no = 5'h13;
    logic [31:0] rdata;
    logic [31:0] dmi_rdata;
    logic rvalid, pme_link, gen2, d35, ari, cto_dis, c_de, c_sos, mod_c, up_de, a_dis, e_comp;
    logic [15:0] link_id, cto_ms;
    logic [3:0] cto_rng, tspeed;
    logic [2:0] margin;
    logic [1:0] pstate;
    int num_errors = 0;
    int cmp_count = 0;

    always #2 clk = ~clk;

    rpcap_link_model link_u (.clk_i(clk), .pme_o(pme_link), .reqid_o(link_id), .gen2_o(gen2),
        .deemph_3p5_o(d35));

    rpcap_regs dut_u (.clk_i(clk), .reset_i(rst), .pwrgood_reset_i(pg_rst), .clk_en_i(en),
        .cfg_wr_i(wr), .cfg_rd_i(rd), .cfg_addr_i(addr), .cfg_be_i(be), .cfg_wdata_i(wdata),
        .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid), .pme_link_i(pme_link),
        .pme_link_reqid_i(link_id), .pme_internal_i(pme_int), .port_bus_number_i(bus_no),
        .port_device_number_i(dev_no), .link_gen2_i(gen2), .link_deemph_3p5_i(d35),
        .ari_enable_o(ari), .cto_disable_o(cto_dis), .cto_range_o(cto_rng),
        .cto_timeout_ms_o(cto_ms), .compliance_deemph_3p5_o(c_de), .compliance_sos_o(c_sos),
        .enter_mod_compliance_o(mod_c), .transmit_margin_o(margin), .upstream_deemph_3p5_o(up_de),
        .autonomous_speed_disable_o(a_dis), .enter_compliance_o(e_comp),
        .target_speed_o(tspeed), .power_state_o(pstate));

    // Second bank built as the DMI function, sharing every input with the first
    rpcap_regs #(.IS_DMI(1'b1)) dmi_u (.clk_i(clk), .reset_i(rst), .pwrgood_reset_i(pg_rst),
        .clk_en_i(en), .cfg_wr_i(wr), .cfg_rd_i(rd), .cfg_addr_i(addr), .cfg_be_i(be),
        .cfg_wdata_i(wdata), .cfg_rdata_o(dmi_rdata), .cfg_rvalid_o(), .pme_link_i(pme_link),
        .pme_link_reqid_i(link_id), .pme_internal_i(pme_int), .port_bus_number_i(bus_no),
        .port_device_number_i(dev_no), .link_gen2_i(gen2), .link_deemph_3p5_i(d35),
        .ari_enable_o(), .cto_disable_o(), .cto_range_o(), .cto_timeout_ms_o(),
        .compliance_deemph_3p5_o(), .compliance_sos_o(), .enter_mod_compliance_o(),
        .transmit_margin_o(), .upstream_deemph_3p5_o(), .autonomous_speed_disable_o(),
        .enter_compliance_o(), .target_speed_o(), .power_state_o());

    task automatic results();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", n, exp, got);
            num_errors++;
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
        @(negedge clk);
        wr = 1'b1;
        addr = a;
        be = b;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
    endtask

    // Read latency is fixed at one cycle, so the valid flag is judged right away
    task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] exp);
        @(negedge clk);
        rd = 1'b1;
        addr = a;
        @(negedge clk);
        rd = 1'b0;
        chk({n, "_valid"}, 32'(rvalid), 32'h1);
        chk(n, rdata, exp);
    endtask

    task automatic t_fixed();
        rd_chk("root_cap", 8'hac, 32'h0001_0000);
        rd_chk("device_capabilities_two", 8'hb4, 32'h0000_003e);
        rd_chk("pm_cap", 8'he0, 32'hc803_0001);
        chk("pm_cap_dmi", dmi_rdata, 32'h0000_0000);
        rd_chk("lnk_rst", 8'hc0, 32'h0000_0002);
        wr_reg(8'hf0, 4'hf, 32'hffff_ffff);
        rd_chk("unmapped", 8'hf0, 32'h0000_0000);
        wr_reg(8'hb4, 4'hf, 32'h0000_0000);
        rd_chk("device_capabilities_two_ro", 8'hb4, 32'h0000_003e);
    endtask

    task automatic t_pme();
        link_u.send_pme(16'h1234);
        rd_chk("pme_first", 8'hb0, 32'h0001_1234);
        link_u.send_pme(16'h5678);
        rd_chk("pme_queued", 8'hb0, 32'h0003_1234);
        wr_reg(8'hb0, 4'hf, 32'h0000_0000);
        rd_chk("pme_wr0", 8'hb0, 32'h0003_1234);
        wr_reg(8'hb0, 4'h4, 32'h0001_0000);
        rd_chk("pme_deliver", 8'hb0, 32'h0001_5678);
        wr_reg(8'hb0, 4'h4, 32'h0001_0000);
        rd_chk("pme_clear", 8'hb0, 32'h0000_5678);
        @(negedge clk);
        pme_int = 1'b1;
        @(negedge clk);
        pme_int = 1'b0;
        rd_chk("pme_virtual", 8'hb0, {16'h0001, bus_no, dev_no, 3'b000});
    endtask

    task automatic t_devctl();
        logic [3:0] codes [8] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h6, 4'h9, 4'ha, 4'hd};
        logic [3:0] rngs [8] = '{4'h0, 4'h0, 4'h0, 4'h5, 4'h6, 4'h9, 4'ha, 4'hd};
        logic [15:0] ms [8] = '{16'd30, 16'd30, 16'd30, 16'd40, 16'd130, 16'd500, 16'd2000,
            16'd8000};
        int i;
        wr_reg(8'hb8, 4'hf, 32'hffff_fff5);
        rd_chk("devctl2", 8'hb8, 32'h0000_0035);
        chk("ari_en", 32'(ari), 32'h1);
        chk("cto_dis", 32'(cto_dis), 32'h1);
        for (i = 0; i < 8; i++) begin
            wr_reg(8'hb8, 4'h1, {28'h0, codes[i]});
            chk("cto_dis_off", 32'(cto_dis), 32'h0);
            chk("cto_range", 32'(cto_rng), 32'(rngs[i]));
            chk("cto_ms", 32'(cto_ms), 32'(ms[i]));
        end
        wr_reg(8'he8, 4'h1, 32'h0000_0005);
        wr_reg(8'hb8, 4'h1, 32'h0000_000e);
        chk("cto_fine", 32'(cto_ms), 32'd17920);
    endtask

    task automatic t_link();
        link_u.set_link(1'b0, 1'b1);
        wr_reg(8'hc0, 4'h3, 32'h0000_1ef1);
        rd_chk("lnkctl2", 8'hc0, 32'h0000_1ef1);
        chk("comp_deemph", 32'(c_de), 32'h1);
        chk("comp_sos", 32'(c_sos), 32'h1);
        chk("mod_comp", 32'(mod_c), 32'h1);
        chk("margin", 32'(margin), 32'h5);
        chk("up_deemph_g1", 32'(up_de), 32'h0);
        chk("auto_dis", 32'(a_dis), 32'h1);
        chk("enter_comp", 32'(e_comp), 32'h1);
        link_u.set_link(1'b1, 1'b1);
        @(negedge clk);
        chk("up_deemph_g2", 32'(up_de), 32'h1);
        wr_reg(8'hc0, 4'h3, 32'h0000_1eb3);
        chk("speed_fallback", 32'(tspeed), 32'h1);
        wr_reg(8'hc0, 4'h3, 32'h0000_1eb2);
        rd_chk("lnk_once", 8'hc0, 32'h0001_1ef2);
        chk("speed_gen2", 32'(tspeed), 32'h2);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        rd_chk("lnk_sticky", 8'hc0, 32'h0001_1e92);
        pg_rst = 1'b1;
        @(negedge clk);
        pg_rst = 1'b0;
        rd_chk("lnk_pwrgood", 8'hc0, 32'h0001_0002);
    endtask

    task automatic t_pm();
        wr_reg(8'he4, 4'hf, 32'hffff_ffff);
        rd_chk("pm_d3", 8'he4, 32'h0000_0003);
        wr_reg(8'he4, 4'h1, 32'h0000_0001);
        chk("pm_keep_d1", 32'(pstate), 32'h3);
        wr_reg(8'he4, 4'h1, 32'h0000_0002);
        chk("pm_keep_d2", 32'(pstate), 32'h3);
        wr_reg(8'he4, 4'h1, 32'h0000_0000);
        rd_chk("pm_d0", 8'he4, 32'h0000_0000);
    endtask

    // Clock enable low must freeze writes, reads and PME capture alike
    task automatic t_hold();
        @(negedge clk);
        en = 1'b0;
        wr_reg(8'he4, 4'h1, 32'h0000_0003);
        chk("hold_pstate", 32'(pstate), 32'h0);
        link_u.send_pme(16'h4321);
        @(negedge clk);
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk("hold_rvalid", 32'(rvalid), 32'h0);
        en = 1'b1;
        rd_chk("hold_pme", 8'hb0, 32'h0000_0000);
        chk("hold_pstate_after", 32'(pstate), 32'h0);
    endtask

    initial begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        pg_rst = 1'b0;
        t_fixed();
        t_pme();
        t_devctl();
        t_link();
        t_pm();
        t_hold();
        results();
    end
endmodule // tb_pcie_root_port_cap_ctrl_regs

`default_nettype wire
